/* verilog/madb_bus_iface.sv */
// multiplexed address/data bus controller with an AHB-Lite register slave
`include "madb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module madb_bus_iface (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic [31:0] ad_i,
    output logic [31:0]      ad_o,
    output logic             ad_oe_o,
    output logic             ale_o,
    output logic             diag_o,
    output logic             read_drive_grant_o,
    input  wire logic [3:0]  addr_lo_i,
    output logic [3:0]       addr_lo_o,
    output logic             addr_lo_oe_o,
    input  wire logic        mem_ack_i
);
    import madb_pkg::*;

    madb_lane_if lane ();
    madb_lane_decode u_dec (.lane(lane));

    madb_state_e st_r;
    madb_state_e st_nxt;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] hrdata_r;
    logic        cfg_big_r;
    logic        cfg_rdinh_r;
    madb_portw_e cfg_pw_r;
    logic        boot_ld_r;
    logic [3:0]  opt_r;
    logic [31:0] addr_r;
    logic [31:0] wdata_r;
    logic [5:0]  cmd_r;
    logic        done_r;
    logic [3:0]  lo_r;
    logic [3:0]  beats_r;
    logic        lo_oe_r;
    logic [31:0] rdbuf_r [4];
    logic        sel_ph;
    logic        reg_wr;
    logic        start;
    logic        is_wr;
    logic        last_beat;
    logic [31:0] pmask;
    logic [4:0]  bit_sh;
    logic [1:0]  buf_idx;
    logic [3:0]  strb_out;
    logic [31:0] rd_mux;

    // ---------------- AHB-Lite slave, zero wait states while clk_en_i is high
    assign sel_ph = hsel_i && htrans_i[1] && hready_i;
    assign reg_wr = wr_pend_r && clk_en_i;
    assign hreadyout_o = clk_en_i;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (clk_en_i) begin
            wr_pend_r <= sel_ph && hwrite_i;
            if (sel_ph) begin
                wr_addr_r <= haddr_i[7:0];
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr_i[7:0])
            `MADB_OFS_CFG:       rd_mux = {28'h0, cfg_pw_r, cfg_rdinh_r, cfg_big_r};
            `MADB_OFS_ADDR:      rd_mux = addr_r;
            `MADB_OFS_WDATA:     rd_mux = wdata_r;
            `MADB_OFS_CMD:       rd_mux = {26'h0, cmd_r};
            `MADB_OFS_STATUS:    rd_mux = {24'h0, opt_r, 2'h0, done_r, !st_r[0]};
            `MADB_OFS_RDBUF:     rd_mux = rdbuf_r[0];
            `MADB_OFS_RDBUF + 8'h04: rd_mux = rdbuf_r[1];
            `MADB_OFS_RDBUF + 8'h08: rd_mux = rdbuf_r[2];
            `MADB_OFS_RDBUF + 8'h0c: rd_mux = rdbuf_r[3];
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hrdata_r <= 32'h0000_0000;
        end else if (clk_en_i && sel_ph && !hwrite_i) begin
            hrdata_r <= rd_mux;
        end
    end

    // ---------------- reset straps on the low address pins
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            opt_r <= addr_lo_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lo_oe_r <= 1'b0; // pins stay inputs while straps are sampled
        end else if (clk_en_i) begin
            lo_oe_r <= 1'b1;
        end
    end

    // ---------------- configuration; boot port width taken from the straps
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cfg_big_r   <= 1'b0;
            cfg_rdinh_r <= 1'b0;
            cfg_pw_r    <= PW_32;
            boot_ld_r   <= 1'b1;
        end else if (clk_en_i) begin
            boot_ld_r <= 1'b0;
            if (boot_ld_r) begin
                cfg_pw_r <= opt_r[`MADB_OPT_BOOT8] ? PW_8 : (opt_r[`MADB_OPT_BOOT16] ? PW_16 : PW_32);
            end else if (reg_wr && wr_addr_r == `MADB_OFS_CFG) begin
                cfg_big_r   <= hwdata_i[`MADB_CFG_BIG];
                cfg_rdinh_r <= hwdata_i[`MADB_CFG_RDINH];
                cfg_pw_r    <= madb_portw_e'(hwdata_i[`MADB_CFG_PW_LSB +: 2]);
            end
        end
    end

    // ---------------- address, write buffer and command
    assign start = reg_wr && wr_addr_r == `MADB_OFS_CMD && st_r == ST_IDLE;
    assign is_wr = cmd_r[`MADB_CMD_WRITE];

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            addr_r  <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            cmd_r   <= `MADB_CMD_RST;
        end else if (clk_en_i) begin
            if (reg_wr && wr_addr_r == `MADB_OFS_ADDR && st_r == ST_IDLE) begin
                addr_r <= hwdata_i;
            end
            if (reg_wr && wr_addr_r == `MADB_OFS_WDATA && st_r == ST_IDLE) begin
                wdata_r <= hwdata_i;
            end
            if (start) begin
                cmd_r <= hwdata_i[5:0];
            end
        end
    end

    assign lane.portw    = cfg_pw_r;
    assign lane.size     = madb_size_e'(cmd_r[`MADB_CMD_SIZE_LSB +: 2]);
    assign lane.big      = cfg_big_r;
    assign lane.quad     = cmd_r[`MADB_CMD_QUAD] && !is_wr;
    assign lane.start_lo = addr_r[3:0];
    assign lane.cur_lo   = lo_r;

    // ---------------- transaction sequencer
    assign last_beat = beats_r == 4'h0;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: if (start) begin
                st_nxt = ST_ADDR; // address phase first
            end
            ST_ADDR: begin
                if (opt_r[`MADB_OPT_EXTHOLD]) begin
                    st_nxt = ST_HOLD;
                end else begin
                    st_nxt = is_wr ? ST_DATA : ST_TURN;
                end
            end
            ST_HOLD: st_nxt = is_wr ? ST_DATA : ST_TURN;
            ST_TURN: st_nxt = ST_DATA;
            ST_DATA: if (mem_ack_i && last_beat) begin
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= ST_IDLE;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    // low address: exact start or zero for quad reads, stepped by port width
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lo_r    <= 4'h0;
            beats_r <= 4'h0;
        end else if (clk_en_i) begin
            if (start) begin
                lo_r <= (hwdata_i[`MADB_CMD_QUAD] && !hwdata_i[`MADB_CMD_WRITE]) ? 4'h0 : addr_r[3:0];
            end else if (st_r == ST_ADDR) begin
                beats_r <= lane.beats_m1;
            end else if (st_r == ST_DATA && mem_ack_i && !last_beat) begin
                lo_r    <= 4'(lo_r + lane.step);
                beats_r <= 4'(beats_r - 4'h1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            done_r <= 1'b0;
        end else if (clk_en_i) begin
            if (st_r == ST_DATA && mem_ack_i && last_beat) begin
                done_r <= 1'b1;
            end else if (start) begin
                done_r <= 1'b0;
            end
        end
    end

    // ---------------- read buffer capture, narrow beats merged into their lanes
    assign pmask   = (cfg_pw_r == PW_16) ? 32'h0000_ffff : ((cfg_pw_r == PW_8) ? 32'h0000_00ff : 32'hffff_ffff);
    assign bit_sh  = {lane.data_sh, 3'b000};
    assign buf_idx = lane.quad ? lo_r[3:2] : 2'h0;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 4; i++) begin
                rdbuf_r[i] <= 32'h0000_0000;
            end
        end else if (clk_en_i && st_r == ST_DATA && !is_wr && mem_ack_i) begin
            rdbuf_r[buf_idx] <= (rdbuf_r[buf_idx] & ~(pmask << bit_sh)) | ((ad_i & pmask) << bit_sh);
        end
    end

    // ---------------- pins
    assign strb_out = (!is_wr && cfg_rdinh_r) ? 4'hf : lane.strb_n;
    assign ale_o    = st_r == ST_ADDR;
    assign ad_oe_o  = st_r == ST_ADDR || st_r == ST_HOLD || (st_r == ST_DATA && is_wr);
    assign ad_o     = (st_r == ST_ADDR || st_r == ST_HOLD) ? {addr_r[31:4], strb_out} :
                      (wdata_r >> bit_sh);
    assign read_drive_grant_o = !is_wr && (st_r == ST_TURN || st_r == ST_DATA);
    assign diag_o   = is_wr ? 1'b0 :
                      (st_r == ST_ADDR || st_r == ST_HOLD) ? cmd_r[`MADB_CMD_MISS] :
                      (st_r == ST_TURN) ? cmd_r[`MADB_CMD_INSTR] : 1'b0;
    assign addr_lo_o    = lo_r;
    assign addr_lo_oe_o = lo_oe_r;

    // ---------------- checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i || !clk_en_i);

    sequence s_addr_ph;
        ale_o && ad_oe_o;
    endsequence
    sequence s_data_ph;
        st_r == ST_DATA;
    endsequence

    a_two_phase_order: assert property (start |=> s_addr_ph ##[1:3] s_data_ph)
        else $error("data phase did not follow address phase");
    a_high_addr_drive: assert property (ale_o |-> ad_o[31:4] == addr_r[31:4] && ad_oe_o)
        else $error("high address not on bus while latch strobe high");
    a_hold_addr: assert property (st_r == ST_HOLD |-> ad_oe_o && !ale_o && ad_o[31:4] == addr_r[31:4])
        else $error("address not held in extended hold cycle");
    a_strobe_lanes: assert property (ale_o |-> ad_o[3:0] == ((!is_wr && cfg_rdinh_r) ? 4'hf : lane.strb_n))
        else $error("byte strobes wrong in address phase");
    a_write_data_out: assert property (st_r == ST_DATA && is_wr |-> ad_oe_o && ad_o == (wdata_r >> bit_sh))
        else $error("write data not driven");
    a_read_release: assert property (st_r == ST_TURN && !is_wr |-> !ad_oe_o && read_drive_grant_o && !ale_o)
        else $error("bus not released before read data");
    a_read_capture: assert property (st_r == ST_DATA && !is_wr && mem_ack_i && cfg_pw_r == PW_32 && !lane.quad
                                     |=> rdbuf_r[0] == $past(ad_i))
        else $error("read word not captured");
    a_quad_lo_start: assert property (start && hwdata_i[`MADB_CMD_QUAD] && !hwdata_i[`MADB_CMD_WRITE]
                                      |=> addr_lo_o == 4'h0)
        else $error("quad read low address not zero");
    a_single_lo_start: assert property (start && !(hwdata_i[`MADB_CMD_QUAD] && !hwdata_i[`MADB_CMD_WRITE])
                                        |=> addr_lo_o == $past(addr_r[3:0]))
        else $error("low address not the exact target");
    a_lo_step: assert property (st_r == ST_DATA && mem_ack_i && !last_beat |=> addr_lo_o == 4'($past(lo_r) + $past(lane.step)))
        else $error("low address step wrong");
    a_diag_miss: assert property (ale_o && !is_wr |-> diag_o == cmd_r[`MADB_CMD_MISS])
        else $error("diagnostic miss flag wrong");
    a_diag_instr: assert property (st_r == ST_TURN && !is_wr |-> diag_o == cmd_r[`MADB_CMD_INSTR])
        else $error("diagnostic instruction flag wrong");
    a_strap_input: assert property (disable iff (1'b0) $past(reset_i) |-> !addr_lo_oe_o)
        else $error("low address driven during reset");
endmodule
`default_nettype wire

/* verilog/madb_map.svh */
// register offsets, field positions and reset values of the multiplexed bus interface
`ifndef MADB_MAP_SVH
`define MADB_MAP_SVH
`define MADB_OFS_CFG        8'h00
`define MADB_OFS_ADDR       8'h04
`define MADB_OFS_WDATA      8'h08
`define MADB_OFS_CMD        8'h0c
`define MADB_OFS_STATUS     8'h10
`define MADB_OFS_RDBUF      8'h20
`define MADB_CFG_BIG        0
`define MADB_CFG_RDINH      1
`define MADB_CFG_PW_LSB     2
`define MADB_CMD_WRITE      0
`define MADB_CMD_SIZE_LSB   1
`define MADB_CMD_QUAD       3
`define MADB_CMD_MISS       4
`define MADB_CMD_INSTR      5
`define MADB_STAT_BUSY      0
`define MADB_STAT_DONE      1
`define MADB_STAT_OPT_LSB   4
`define MADB_OPT_BOOT16     0
`define MADB_OPT_BOOT8      1
`define MADB_OPT_RSVHIGH    2
`define MADB_OPT_EXTHOLD    3
`define MADB_CMD_RST        6'h00
`define MADB_HOLD_CYCLES    1
`endif

/* verilog/madb_pkg.sv */
// types shared by the multiplexed bus interface
package madb_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_HOLD = 5'b00100,
        ST_TURN = 5'b01000,
        ST_DATA = 5'b10000
    } madb_state_e;
    typedef enum logic [1:0] {
        PW_32  = 2'h0,
        PW_16  = 2'h1,
        PW_8   = 2'h2,
        PW_RSV = 2'h3
    } madb_portw_e;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2,
        SZ_RSV  = 2'h3
    } madb_size_e;
endpackage

/* verilog/madb_lane_if.sv */
// lane decode request and answer between the bus controller and the lane decoder
`timescale 1ns/100ps
`default_nettype none
interface madb_lane_if;
    madb_pkg::madb_portw_e portw;
    madb_pkg::madb_size_e  size;
    logic                  big;
    logic                  quad;
    logic [3:0]            start_lo;
    logic [3:0]            cur_lo;
    logic [3:0]            strb_n;
    logic [3:0]            beats_m1;
    logic [3:0]            step;
    logic [1:0]            data_sh;
    modport req (output portw, size, big, quad, start_lo, cur_lo,
                 input strb_n, beats_m1, step, data_sh);
    modport dec (input portw, size, big, quad, start_lo, cur_lo,
                 output strb_n, beats_m1, step, data_sh);
endinterface
`default_nettype wire

/* verilog/madb_lane_decode.sv */
// byte lane, strobe, beat count and step decoder
`timescale 1ns/100ps
`default_nettype none
module madb_lane_decode (
    madb_lane_if.dec lane
);
    import madb_pkg::*;

    // byte offset of a unit inside the word lanes for either byte order
    function automatic logic [1:0] lane_shift(input logic [1:0] unit, input logic [1:0] a,
                                              input logic big);
        logic [1:0] r;
        r = 2'h0;
        if (unit == SZ_BYTE) begin
            r = big ? (2'h3 - a) : a;
        end else if (unit == SZ_HALF) begin
            r = big ? {~a[1], 1'b0} : {a[1], 1'b0};
        end
        return r;
    endfunction

    logic [1:0] pb_log;
    logic [1:0] sb_log;
    logic [1:0] pw_unit;
    logic [3:0] size_mask;

    always_comb begin
        unique case (lane.portw)
            PW_16:   pb_log = 2'h1;
            PW_8:    pb_log = 2'h0;
            default: pb_log = 2'h2;
        endcase
        unique case (lane.size)
            SZ_BYTE: sb_log = 2'h0;
            SZ_HALF: sb_log = 2'h1;
            default: sb_log = 2'h2;
        endcase
    end

    assign pw_unit = 2'(pb_log);
    assign size_mask = (sb_log == 2'h2) ? 4'hf : ((sb_log == 2'h1) ? 4'h3 : 4'h1);
    // active-low lane strobes; only a 32-bit port gives them meaning
    assign lane.strb_n = ~(4'(size_mask << lane_shift(sb_log, lane.start_lo[1:0], lane.big)));
    // beats: datum wider than port splits it, a quad read moves sixteen bytes
    assign lane.beats_m1 = lane.quad ? 4'((5'h10 >> pb_log) - 5'h01) :
                           (sb_log > pb_log) ? 4'((4'h1 << (sb_log - pb_log)) - 4'h1) : 4'h0;
    assign lane.step = 4'(4'h1 << pb_log);
    // lanes carrying the current datum follow port width and byte order
    assign lane.data_sh = lane_shift(pw_unit, lane.cur_lo[1:0], lane.big);
endmodule
`default_nettype wire

/* dv/madb_mem_model.sv */
// external memory and address latch model facing the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module madb_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic [31:0] ad_o,
    input  wire logic        ad_oe_o,
    input  wire logic        ale_o,
    input  wire logic        diag_o,
    input  wire logic        read_drive_grant_o,
    input  wire logic [3:0]  addr_lo_o,
    input  wire logic        addr_lo_oe_o,
    input  wire logic [3:0]  straps_i,
    input  wire logic [3:0]  wait_i,
    output logic [31:0]      ad_pin_o,
    output logic [3:0]       addr_lo_pin_o,
    output logic             mem_ack_o
);
    logic [31:0] last_r;
    logic [31:0] latch_r;
    logic [3:0]  cnt_r;
    logic        grant_d_r;
    logic        ale_d_r;
    logic        miss_s;
    logic        instr_s;
    logic [31:0] wr_q[$];
    logic [3:0]  lo_q[$];
    wire logic   drive = read_drive_grant_o & grant_d_r;
    // the extended hold cycle still carries the address, so no beat is counted there
    wire logic   active = (ad_oe_o & ~ale_o & ~(ale_d_r & straps_i[3])) | drive;
    initial mem_ack_o = 1'b0;
    initial last_r = 32'h0;
    // memory drives only after the grant has stood a cycle; a released bus shows the inverted last level
    assign ad_pin_o = ad_oe_o ? ad_o : drive ? (32'ha500_0000 | {28'h0, addr_lo_o}) : ~last_r;
    assign addr_lo_pin_o = addr_lo_oe_o ? addr_lo_o : straps_i;
    always @(posedge core_clk_i) begin
        last_r <= ad_pin_o;
        grant_d_r <= read_drive_grant_o & ~reset_i;
        ale_d_r <= ale_o;
        // strobes are latched but never used as enables, as for a narrow port
        if (ale_o) begin
            latch_r <= ad_o;
            miss_s <= diag_o;
        end
        if (read_drive_grant_o & ~grant_d_r) instr_s <= diag_o;
        if (reset_i | mem_ack_o) begin
            mem_ack_o <= 1'b0;
            cnt_r <= 4'h0;
        end else if (active) begin
            if (cnt_r == wait_i) mem_ack_o <= 1'b1;
            else cnt_r <= cnt_r + 4'h1;
        end
        if (mem_ack_o & ~reset_i) begin
            lo_q.push_back(addr_lo_o);
            if (ad_oe_o) wr_q.push_back(ad_o);
        end
    end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the multiplexed bus interface
`include "madb_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0]  straps = 4'h4;
    logic [3:0]  wait_n = 4'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] ad_i;
    logic [31:0] ad_o;
    logic        ad_oe;
    logic        ale;
    logic        diag;
    logic        grant;
    logic [3:0]  lo_i;
    logic [3:0]  lo_o;
    logic        lo_oe;
    logic        ack;
    int          miscompares = 0;
    int          num_checks = 0;
    always #5 core_clk_i = ~core_clk_i;
    madb_bus_iface dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .ad_i(ad_i),
        .ad_o(ad_o), .ad_oe_o(ad_oe), .ale_o(ale), .diag_o(diag), .read_drive_grant_o(grant),
        .addr_lo_i(lo_i), .addr_lo_o(lo_o), .addr_lo_oe_o(lo_oe), .mem_ack_i(ack));
    madb_mem_model mem (.core_clk_i(core_clk_i), .reset_i(reset_i), .ad_o(ad_o), .ad_oe_o(ad_oe),
        .ale_o(ale), .diag_o(diag), .read_drive_grant_o(grant), .addr_lo_o(lo_o), .addr_lo_oe_o(lo_oe),
        .straps_i(straps), .wait_i(wait_n), .ad_pin_o(ad_i), .addr_lo_pin_o(lo_i), .mem_ack_o(ack));
    task final_report();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task ready_edge();
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        ready_edge();
        htrans <= 2'h0;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task run(input logic [31:0] a, input logic [31:0] d, input logic [5:0] cmd);
        logic [31:0] s;
        int n;
        mem.lo_q.delete();
        mem.wr_q.delete();
        wr(`MADB_OFS_ADDR, a);
        wr(`MADB_OFS_WDATA, d);
        wr(`MADB_OFS_CMD, {26'h0, cmd});
        n = 0;
        s = 32'h1;
        while (s[`MADB_STAT_BUSY] !== 1'b0 || s[`MADB_STAT_DONE] !== 1'b1) begin
            ahb(1'b0, `MADB_OFS_STATUS, 32'h0, s);
            n++;
            if (n > 200) begin
                miscompares++;
                final_report();
            end
        end
    endtask
    task do_reset(input logic [3:0] st);
        straps <= st;
        reset_i <= 1'b1;
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task t_reset(input logic [3:0] st);
        logic [31:0] s;
        do_reset(st);
        `CHK({ad_oe, ale, grant, diag, hresp, hrdata}, 37'h0)
        ahb(1'b0, `MADB_OFS_STATUS, 32'h0, s);
        `CHK(s[7:4], st)
        `CHK(lo_oe, 1'b1)
        ahb(1'b0, 8'h3c, 32'h0, s);
        `CHK(s, 32'h0)
    endtask
    task t_writes();
        wr(`MADB_OFS_CFG, 32'h0);
        run(32'h8765_4320, 32'hdead_beef, 6'h05);
        `CHK(mem.latch_r, 32'h8765_4320)
        `CHK(mem.wr_q[0], 32'hdead_beef)
        `CHK(mem.lo_q.size(), 1)
        for (int b = 0; b < 2; b++) begin
            wr(`MADB_OFS_CFG, b);
            run(32'h0000_0101, 32'h0000_5a5a, 6'h01);
            `CHK(mem.latch_r[3:0], b ? 4'b1011 : 4'b1101)
            `CHK(mem.lo_q[0], 4'h1)
        end
    endtask
    task t_reads();
        logic [31:0] s;
        for (int k = 0; k < 2; k++) begin
            wait_n <= 4'h2;
            wr(`MADB_OFS_CFG, k ? 32'h2 : 32'h0);
            run(k ? 32'h2000_0004 : 32'h2000_0008, 32'h0, k ? 6'h04 : 6'h34);
            `CHK(mem.latch_r[3:0], k ? 4'hf : 4'h0)
            `CHK({mem.miss_s, mem.instr_s}, k ? 2'b00 : 2'b11)
            ahb(1'b0, `MADB_OFS_RDBUF, 32'h0, s);
            `CHK(s, k ? 32'ha500_0004 : 32'ha500_0008)
        end
        wait_n <= 4'h0;
        run(32'h3000_0004, 32'h0, 6'h0c);
        `CHK(mem.lo_q.size(), 4)
        for (int i = 0; i < 4; i++) begin
            `CHK(mem.lo_q[i], 4'(4 * i))
            ahb(1'b0, 8'(`MADB_OFS_RDBUF + 4 * i), 32'h0, s);
            `CHK(s, 32'ha500_0000 | (4 * i))
        end
    endtask
    task t_port16();
        logic [31:0] s;
        t_reset(4'h9);
        run(32'h0000_0040, 32'h1234_5678, 6'h05);
        `CHK(mem.lo_q.size(), 2)
        `CHK({mem.lo_q[0], mem.lo_q[1]}, 8'h02)
        `CHK({mem.wr_q[0][15:0], mem.wr_q[1][15:0]}, 32'h5678_1234)
        run(32'h0000_0046, 32'h0, 6'h0c);
        `CHK(mem.lo_q.size(), 8)
        for (int i = 0; i < 8; i++) `CHK(mem.lo_q[i], 4'(2 * i))
        ahb(1'b0, 8'(`MADB_OFS_RDBUF + 4), 32'h0, s);
        `CHK(s, 32'h0006_0004)
    endtask
    initial begin
        t_reset(4'h4);
        t_writes();
        t_reads();
        t_port16();
        final_report();
    end
endmodule
`default_nettype wire
